// >>> pkg/bbx_pkg.sv
// Constants shared by the bit/branch/skip/xor execution block
package bbx_pkg;

  // Quarter-cycle timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int QTR_TIME_NS   = 200;
  localparam int QTR_CLKS      =
    (QTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QCNT_W        = 2;

  // Quarter phases
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // Execution sequencer
  typedef enum logic [1:0] {
    ST_EXEC   = 2'h0,
    ST_FLUSH1 = 2'h1,
    ST_FLUSH2 = 2'h3
  } bbx_state_t;

  // Opcode patterns
  localparam logic [3:0]  OPC_BIT_INV  = 4'h7;
  localparam logic [7:0]  OPC_BR_OV    = 8'he4;
  localparam logic [6:0]  OPC_TST_SKIP = 7'h33;
  localparam logic [7:0]  OPC_XOR_LIT  = 8'h0a;
  localparam logic [15:0] OPC_NO_OP    = 16'h0000;

  // Data addressing
  localparam logic [7:0]  IDX_LIMIT    = 8'h5f;
  localparam logic [7:0]  ACC_SPLIT    = 8'h80;
  localparam logic [3:0]  ACC_HI_BANK  = 4'hf;
  localparam logic [3:0]  ACC_LO_BANK  = 4'h0;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_WREG = 8'h08;
  localparam logic [7:0] OFS_FSR  = 8'h0c;
  localparam logic [7:0] OFS_PC   = 8'h10;
  localparam logic [7:0] OFS_INFO = 8'h14;

  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int CTRL_BSR_LSB = 8;
  localparam int STAT_Z_BIT   = 0;
  localparam int STAT_OV_BIT  = 1;
  localparam int STAT_N_BIT   = 2;
  localparam int INFO_ST_LSB  = 16;

  // Reset values
  localparam logic [3:0]  RST_BSR  = 4'h0;
  localparam logic [11:0] RST_FSR  = 12'h000;
  localparam logic [7:0]  RST_W    = 8'h00;
  localparam logic [20:0] RST_PC   = 21'h000000;
  localparam logic        RST_RUN  = 1'b0;
  localparam logic        RST_EXT  = 1'b0;

endpackage

// >>> rtl/bbx_core.sv
// Execution unit for bit toggle, overflow branch, test-skip and xor
module bbx_core
  import bbx_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic [15:0] IR_I,
  input  wire logic        NEXT_TWO_WORD_I,
  output logic      [20:0] PC_O,
  output logic             FETCH_FLUSH_O,
  output logic      [1:0]  QPHASE_O,
  output logic             QSTB_O,
  output logic      [11:0] DM_ADDR_O,
  input  wire logic [7:0]  DM_RDATA_I,
  output logic      [7:0]  DM_WDATA_O,
  output logic             DM_RE_O,
  output logic             DM_WE_O
);

  function automatic logic is_bit_inv(input logic [15:0] ir);
    return ir[15:12] == OPC_BIT_INV;
  endfunction

  function automatic logic is_br_ov(input logic [15:0] ir);
    return ir[15:8] == OPC_BR_OV;
  endfunction

  function automatic logic is_tst_skip(input logic [15:0] ir);
    return ir[15:9] == OPC_TST_SKIP;
  endfunction

  function automatic logic is_xor_lit(input logic [15:0] ir);
    return ir[15:8] == OPC_XOR_LIT;
  endfunction

  function automatic logic is_file_op(input logic [15:0] ir);
    return is_bit_inv(ir) | is_tst_skip(ir);
  endfunction

  // Signed word offset times two, widened to the counter
  function automatic logic [20:0] br_disp(input logic [7:0] n);
    return {{12{n[7]}}, n, 1'b0};
  endfunction

  // Control and state registers
  logic        run_q;
  logic        ext_q;
  logic [3:0]  bsr_q;
  logic [11:0] fsr_q;
  logic [7:0]  w_q;
  logic        n_q;
  logic        z_q;
  logic        ov_q;
  logic [20:0] pc_q;
  bbx_state_t  st_q;

  // Pipeline registers
  logic [15:0] ir_q;
  logic [7:0]  data_q;
  logic [7:0]  xor_res_q;
  logic        skip_q;
  logic        skip_two_q;
  logic        take_q;
  logic        br_hold_q;
  logic [11:0] dm_addr_q;
  logic [7:0]  dm_wdata_q;
  logic        dm_re_q;
  logic        dm_we_q;
  logic        flush_q;
  logic [31:0] prdata_q;

  logic        q_stb;
  logic [1:0]  q_ph;
  logic [11:0] ea_addr;
  logic        stb_q1;
  logic        stb_q2;
  logic        stb_q3;
  logic        stb_q4;

  // APB decode
  logic        apb_wr;
  logic        apb_rd_setup;
  logic        addr_hit;
  logic [31:0] rd_mux;

  bbx_qgen u_qgen (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .run_i   (run_q),
    .stb_o   (q_stb),
    .phase_o (q_ph)
  );

  bbx_ea u_ea (
    .f_i    (IR_I[7:0]),
    .acc_i  (IR_I[8]),
    .bsr_i  (bsr_q),
    .ext_i  (ext_q),
    .fsr_i  (fsr_q),
    .addr_o (ea_addr)
  );

  assign stb_q1 = q_stb & (q_ph == PH_Q1);
  assign stb_q2 = q_stb & (q_ph == PH_Q2);
  assign stb_q3 = q_stb & (q_ph == PH_Q3);
  assign stb_q4 = q_stb & (q_ph == PH_Q4);

  assign addr_hit = (PADDR_I == OFS_CTRL) | (PADDR_I == OFS_STAT) |
                    (PADDR_I == OFS_WREG) | (PADDR_I == OFS_FSR)  |
                    (PADDR_I == OFS_PC)   | (PADDR_I == OFS_INFO);
  assign apb_wr       = PSEL_I & PENABLE_I & PWRITE_I & addr_hit;
  assign apb_rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR_I)
      OFS_CTRL: begin
        rd_mux[CTRL_RUN_BIT]              = run_q;
        rd_mux[CTRL_EXT_BIT]              = ext_q;
        rd_mux[CTRL_BSR_LSB +: 4]         = bsr_q;
      end
      OFS_STAT: begin
        rd_mux[STAT_Z_BIT]                = z_q;
        rd_mux[STAT_OV_BIT]               = ov_q;
        rd_mux[STAT_N_BIT]                = n_q;
      end
      OFS_WREG: rd_mux[7:0]               = w_q;
      OFS_FSR:  rd_mux[11:0]              = fsr_q;
      OFS_PC:   rd_mux[20:0]              = pc_q;
      OFS_INFO: begin
        rd_mux[15:0]                      = ir_q;
        rd_mux[INFO_ST_LSB +: 2]          = st_q;
      end
      default:  rd_mux                    = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup phase, valid in the access phase
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_rd_setup) begin
      prdata_q <= rd_mux;
    end
  end

  assign PRDATA_O  = prdata_q;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_hit;

  // Control register
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      run_q <= RST_RUN;
      ext_q <= RST_EXT;
      bsr_q <= RST_BSR;
    end else if (apb_wr && PADDR_I == OFS_CTRL) begin
      run_q <= PWDATA_I[CTRL_RUN_BIT];
      ext_q <= PWDATA_I[CTRL_EXT_BIT];
      bsr_q <= PWDATA_I[CTRL_BSR_LSB +: 4];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      fsr_q <= RST_FSR;
    end else if (apb_wr && PADDR_I == OFS_FSR) begin
      fsr_q <= PWDATA_I[11:0];
    end
  end

  // Decode: take the fetched word in Q1, or a no-op while flushing
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ir_q      <= OPC_NO_OP;
      dm_addr_q <= 12'h000;
    end else if (stb_q1) begin
      if (st_q == ST_EXEC) begin
        ir_q <= IR_I;
      end else begin
        ir_q <= OPC_NO_OP;
      end
      dm_addr_q <= ea_addr;
    end
  end

  // Operand read during Q2
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      dm_re_q <= 1'b0;
      data_q  <= 8'h00;
    end else if (stb_q1) begin
      dm_re_q <= (st_q == ST_EXEC) & is_file_op(IR_I);
    end else if (stb_q2) begin
      dm_re_q <= 1'b0;
      data_q  <= DM_RDATA_I;
    end
  end

  // Process data in Q3, write back during Q4
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      dm_we_q    <= 1'b0;
      dm_wdata_q <= 8'h00;
      xor_res_q  <= 8'h00;
      skip_q     <= 1'b0;
      skip_two_q <= 1'b0;
      take_q     <= 1'b0;
    end else if (stb_q3) begin
      dm_we_q    <= is_bit_inv(ir_q);
      dm_wdata_q <= data_q ^ (8'h01 << ir_q[11:9]);
      xor_res_q  <= w_q ^ ir_q[7:0];
      skip_q     <= is_tst_skip(ir_q) & (data_q == 8'h00);
      skip_two_q <= NEXT_TWO_WORD_I;
      take_q     <= is_br_ov(ir_q) & ov_q;
    end else if (stb_q4) begin
      dm_we_q    <= 1'b0;
    end
  end

  // Working register, hardware update wins over a bus write
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      w_q <= RST_W;
    end else if (stb_q4 && is_xor_lit(ir_q)) begin
      w_q <= xor_res_q;
    end else if (apb_wr && PADDR_I == OFS_WREG) begin
      w_q <= PWDATA_I[7:0];
    end
  end

  // Negative and zero flags; only the xor instruction and a bus write touch them
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      n_q <= 1'b0;
      z_q <= 1'b0;
    end else if (stb_q4 && is_xor_lit(ir_q)) begin
      n_q <= xor_res_q[7];
      z_q <= (xor_res_q == 8'h00);
    end else if (apb_wr && PADDR_I == OFS_STAT) begin
      n_q <= PWDATA_I[STAT_N_BIT];
      z_q <= PWDATA_I[STAT_Z_BIT];
    end
  end

  // Overflow flag is an input to this block, set by software only
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ov_q <= 1'b0;
    end else if (apb_wr && PADDR_I == OFS_STAT) begin
      ov_q <= PWDATA_I[STAT_OV_BIT];
    end
  end

  // Program counter advances one word per cycle, or branches in Q4;
  // it holds through the dead cycle so the target is not passed over
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pc_q <= RST_PC;
    end else if (stb_q4) begin
      if (take_q) begin
        pc_q <= pc_q + 21'h000002 + br_disp(ir_q[7:0]);
      end else if (!br_hold_q) begin
        pc_q <= pc_q + 21'h000002;
      end
    end else if (apb_wr && PADDR_I == OFS_PC) begin
      pc_q <= PWDATA_I[20:0];
    end
  end

  // Refetch request after a taken branch
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= stb_q4 & take_q;
    end
  end

  // Marks the no-op cycle that follows a taken branch
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      br_hold_q <= 1'b0;
    end else if (stb_q4) begin
      br_hold_q <= take_q;
    end
  end

  // Flush sequencer: counts discarded cycles
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st_q <= ST_EXEC;
    end else if (stb_q4) begin
      case (st_q)
        ST_EXEC: begin
          if (take_q) begin
            st_q <= ST_FLUSH1;
          end else if (skip_q && skip_two_q) begin
            st_q <= ST_FLUSH2;
          end else if (skip_q) begin
            st_q <= ST_FLUSH1;
          end else begin
            st_q <= ST_EXEC;
          end
        end
        ST_FLUSH2: st_q <= ST_FLUSH1;
        ST_FLUSH1: st_q <= ST_EXEC;
        default:   st_q <= ST_EXEC;
      endcase
    end
  end

  assign PC_O          = pc_q;
  assign FETCH_FLUSH_O = flush_q;
  assign QPHASE_O      = q_ph;
  assign QSTB_O        = q_stb;
  assign DM_ADDR_O     = dm_addr_q;
  assign DM_WDATA_O    = dm_wdata_q;
  assign DM_RE_O       = dm_re_q;
  assign DM_WE_O       = dm_we_q;

endmodule

// >>> rtl/bbx_ea.sv
// Effective data address for file-register operands
module bbx_ea
  import bbx_pkg::*;
(
  input  wire logic [7:0]  f_i,
  input  wire logic        acc_i,
  input  wire logic [3:0]  bsr_i,
  input  wire logic        ext_i,
  input  wire logic [11:0] fsr_i,
  output logic      [11:0] addr_o
);

  always_comb begin
    if (acc_i) begin
      addr_o = {bsr_i, f_i};
    end else if (ext_i && f_i <= IDX_LIMIT) begin
      addr_o = fsr_i + {4'h0, f_i};
    end else if (f_i >= ACC_SPLIT) begin
      addr_o = {ACC_HI_BANK, f_i};
    end else begin
      addr_o = {ACC_LO_BANK, f_i};
    end
  end

endmodule

// >>> rtl/bbx_qgen.sv
// Quarter-cycle enable and phase generator
module bbx_qgen
  import bbx_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  output logic            stb_o,
  output logic [1:0]      phase_o
);

  logic [QCNT_W-1:0] cnt_q;

  // Last clock of a quarter
  assign stb_o = run_i & (cnt_q == QCNT_W'(QTR_CLKS - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q   <= '0;
      phase_o <= PH_Q1;
    end else if (stb_o) begin
      cnt_q   <= '0;
      phase_o <= phase_o + 2'h1;
    end else if (run_i) begin
      cnt_q   <= cnt_q + QCNT_W'(1);
    end
  end

endmodule

// >>> verification/bbx_core_chk.sv
// Port-level checker for the execution block
module bbx_core_chk
  import bbx_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic        PSLVERR_O,
  input wire logic [20:0] PC_O,
  input wire logic        FETCH_FLUSH_O,
  input wire logic [1:0]  QPHASE_O,
  input wire logic        QSTB_O,
  input wire logic [11:0] DM_ADDR_O,
  input wire logic [7:0]  DM_WDATA_O,
  input wire logic        DM_RE_O,
  input wire logic        DM_WE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  property p_re; DM_RE_O |-> QPHASE_O == PH_Q2; endproperty
  a_re: assert property (p_re) else $error("read outside Q2");
  property p_we; DM_WE_O |-> QPHASE_O == PH_Q4; endproperty
  a_we: assert property (p_we) else $error("write outside Q4");
  property p_weh; $rose(DM_WE_O) |=> DM_WE_O && $stable(DM_WDATA_O); endproperty
  a_weh: assert property (p_weh) else $error("write strobe short");
  property p_adr; $past(DM_RE_O) |-> $stable(DM_ADDR_O); endproperty
  a_adr: assert property (p_adr) else $error("address moved");
  property p_fl;
    FETCH_FLUSH_O |-> $past(QSTB_O) && $past(QPHASE_O) == PH_Q4;
  endproperty
  a_fl: assert property (p_fl) else $error("flush off Q4");
  property p_fl1; FETCH_FLUSH_O |=> !FETCH_FLUSH_O [*2]; endproperty
  a_fl1: assert property (p_fl1) else $error("flush too long");
  property p_pc;
    $changed(PC_O) && !$past(PSEL_I && PENABLE_I && PWRITE_I)
      |-> $past(QSTB_O && QPHASE_O == PH_Q4);
  endproperty
  a_pc: assert property (p_pc) else $error("PC moved off Q4");
  property p_q; QSTB_O |=> QPHASE_O == $past(QPHASE_O) + 2'h1; endproperty
  a_q: assert property (p_q) else $error("quarter stuck");
  property p_err;
    PSEL_I && PENABLE_I && PADDR_I > OFS_INFO |-> PSLVERR_O;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
  c_fl: cover property (FETCH_FLUSH_O);
  c_we: cover property (DM_WE_O);
  c_err: cover property (PSLVERR_O);
endmodule

bind bbx_core bbx_core_chk bbx_core_chk_i (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PSLVERR_O(PSLVERR_O), .PC_O(PC_O), .FETCH_FLUSH_O(FETCH_FLUSH_O),
  .QPHASE_O(QPHASE_O), .QSTB_O(QSTB_O), .DM_ADDR_O(DM_ADDR_O),
  .DM_WDATA_O(DM_WDATA_O), .DM_RE_O(DM_RE_O), .DM_WE_O(DM_WE_O));

// >>> verification/bbx_core_tb.sv
// Self-checking bench for the execution block
module bbx_core_tb
  import bbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [15:0] i0, i1;
    logic [7:0]  w, st;
    logic [11:0] ctl;
    int          cyc;
    logic        tw;
    logic [7:0]  ew, est;
    logic [20:0] epc;
    logic [11:0] da;
    logic [7:0]  dv, edv;
  } bbx_row_t;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, flush, qstb, two, re, we;
  logic [7:0]  paddr = 8'h00, rdm, wdm;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [15:0] ir;
  logic [20:0] pc;
  logic [1:0]  qph;
  logic [11:0] dma;
  logic        rerr;
  int          failures = 0, num_checks = 0;
  bbx_row_t    r;
  bbx_row_t    rows [15] = '{
    '{16'h0aaf, 0, 8'hb5, 0, 12'h001, 1, 0, 8'h1a, 0, 2, 0, 0, 0},
    '{16'h0a80, 0, 8'h00, 0, 12'h001, 1, 0, 8'h80, 4, 2, 0, 0, 0},
    '{16'h0a5a, 0, 8'h5a, 2, 12'h001, 1, 0, 8'h00, 3, 2, 0, 0, 0},
    '{16'h7910, 0, 8'h11, 7, 12'h001, 1, 0, 8'h11, 7, 2, 12'h010, 8'h75, 8'h65},
    '{16'h7e90, 0, 8'h11, 0, 12'h001, 1, 0, 8'h11, 0, 2, 12'hf90, 0, 8'h80},
    '{16'h705f, 0, 8'h11, 0, 12'h003, 1, 0, 8'h11, 0, 2, 12'h35f, 1, 0},
    '{16'h7060, 0, 8'h11, 0, 12'h003, 1, 0, 8'h11, 0, 2, 12'h060, 0, 1},
    '{16'h7344, 0, 8'h11, 0, 12'h201, 1, 0, 8'h11, 0, 2, 12'h244, 0, 2},
    '{16'he403, 16'h0aff, 8'h11, 2, 12'h001, 1, 0, 8'h11, 2, 8, 0, 0, 0},
    '{16'he4ff, 16'h0aff, 8'h11, 2, 12'h001, 1, 0, 8'h11, 2, 0, 0, 0, 0},
    '{16'he400, 16'h0aff, 8'h11, 2, 12'h001, 3, 0, 8'hee, 6, 4, 0, 0, 0},
    '{16'he403, 16'h0aff, 8'h11, 0, 12'h001, 2, 0, 8'hee, 4, 4, 0, 0, 0},
    '{16'h6730, 16'h0aff, 8'h11, 0, 12'h001, 3, 0, 8'hee, 4, 6, 12'h030, 0, 0},
    '{16'h6730, 16'h0aff, 8'h11, 0, 12'h001, 3, 1, 8'h11, 0, 6, 12'h030, 0, 0},
    '{16'h6730, 16'h0aff, 8'h11, 0, 12'h001, 2, 0, 8'hee, 4, 4, 12'h030, 5, 5}
  };

  bbx_core bbx_core_i (
    .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .IR_I(ir), .NEXT_TWO_WORD_I(two), .PC_O(pc), .FETCH_FLUSH_O(flush),
    .QPHASE_O(qph), .QSTB_O(qstb), .DM_ADDR_O(dma), .DM_RDATA_I(rdm),
    .DM_WDATA_O(wdm), .DM_RE_O(re), .DM_WE_O(we));
  bbx_mem bbx_mem_i (
    .clk_i(clk), .pc_i(pc), .addr_i(dma), .re_i(re), .we_i(we),
    .wdata_i(wdm), .ir_o(ir), .two_word_o(two), .rdata_o(rdm));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      r = rows[i];
      for (int j = 0; j < 16; j++)
        bbx_mem_i.prog[j] = (j == 0) ? r.i0 : (j < 4) ? r.i1 : OPC_NO_OP;
      bbx_mem_i.dmem[r.da] = r.dv;
      bbx_mem_i.two_word = r.tw;
      apb(1'b1, OFS_WREG, 32'(r.w));
      apb(1'b1, OFS_STAT, 32'(r.st));
      apb(1'b1, OFS_FSR, 32'h300);
      apb(1'b1, OFS_CTRL, 32'(r.ctl));
      repeat (r.cyc) do @(posedge clk); while (!(qstb && qph == PH_Q4));
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b0, OFS_WREG, 32'h0);
      chk("wreg", 32'(r.ew), rdat);
      apb(1'b0, OFS_STAT, 32'h0);
      chk("flags", 32'(r.est[2:0]), rdat);
      apb(1'b0, OFS_PC, 32'h0);
      chk("pc", 32'(r.epc), rdat);
      chk("data", 32'(r.edv), 32'(bbx_mem_i.dmem[r.da]));
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
    end
    apb(1'b1, OFS_CTRL, 32'h0000_0f02);
    apb(1'b1, OFS_WREG, 32'h0000_005a);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl set", 32'h0000_0f02, rdat);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rdat);
    apb(1'b0, OFS_WREG, 32'h0);
    chk("wreg reset", 32'h0, rdat);
    apb(1'b1, 8'h18, 32'hffff_ffff);
    chk("unmapped err", 32'h1, 32'(rerr));
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped read", 32'h0, rdat);
    finish_test();
  end
endmodule

// >>> verification/bbx_mem.sv
// Program store and data memory facing the block
module bbx_mem
  import bbx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic [20:0] pc_i,
  input  wire logic [11:0] addr_i,
  input  wire logic        re_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [15:0] ir_o,
  output logic             two_word_o,
  output logic      [7:0]  rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] prog [16];
  logic [7:0]  dmem [4096];
  logic        two_word = 1'b0;
  assign ir_o       = prog[pc_i[4:1]];
  assign two_word_o = two_word;
  // Unread bus shows inverted data
  assign rdata_o = re_i ? dmem[addr_i] : ~dmem[addr_i];
  always @(posedge clk_i) begin
    if (we_i) begin
      dmem[addr_i] <= wdata_i;
    end
  end
endmodule
